// ---- rtl/encoder_word_defines.svh ----
`ifndef ENCODER_WORD_DEFINES_SVH
`define ENCODER_WORD_DEFINES_SVH

// word offsets on the register bus (byte addresses)
`define POS_HIGH_OFS 8'h00
`define POS_LOW_OFS 8'h04
`define POS_HOLD_OFS 8'h08
`define TMR_HIGH_OFS 8'h0c
`define TMR_LOW_OFS 8'h10
`define CTRL_OFS 8'h14

// control register fields
`define CTRL_POS_EN_BIT 0
`define CTRL_TMR_EN_BIT 1
`define CTRL_DIR_BIT 2

// reset values
`define WORD16_RESET 16'h0000
`define CTRL_RESET 3'h0

// layout: the high 16-bit half sits in bits 31:16 of each 32-bit value
`define HALF_SHIFT 16

`endif

// ---- rtl/encoder_word_pkg.sv ----
package encoder_word_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } bus_phase_t;
  typedef logic [15:0] half_word_t;
  typedef logic [31:0] full_word_t;
endpackage : encoder_word_pkg

// ---- rtl/word_counter32.sv ----
`timescale 1ns/1ps
`include "encoder_word_defines.svh"

// 32-bit counter with separate loads for each half
module word_counter32 (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic count_en_in,
  input wire logic count_down_in,
  input wire logic load_high_in,
  input wire logic load_low_in,
  input wire logic [15:0] high_data_in,
  input wire logic [15:0] low_data_in,
  output logic [31:0] value_out
);
  logic [31:0] value_reg;
  logic [31:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (count_en_in) begin
      value_next = count_down_in ? value_reg - 32'h0000_0001 : value_reg + 32'h0000_0001;
    end
    if (load_high_in) begin
      value_next[31:16] = high_data_in;
    end
    if (load_low_in) begin
      value_next[15:0] = low_data_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      value_reg <= 32'h0000_0000;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_out = value_reg;
endmodule : word_counter32

// ---- rtl/encoder_counter_word_access.sv ----
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "encoder_word_defines.svh"
//
// Overview of operation
// - position high register holds count bits 31:16
// - position low register holds count bits 15:0
// - hold register carries the position high word
// - timer high register reads/writes bits 31:16
// - timer low register reads/writes bits 15:0
module encoder_counter_word_access (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic pos_step_in,
  input wire logic pos_dir_in,
  input wire logic tmr_tick_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] position_count_32_out,
  output logic [31:0] interval_timer_32_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] step_sync_reg;
  logic [1:0] dir_sync_reg;
  logic [1:0] tick_sync_reg;
  logic step_prev_reg;
  logic tick_prev_reg;
  logic [1:0] step_sync_next;
  logic [1:0] dir_sync_next;
  logic [1:0] tick_sync_next;

  always_comb begin
    step_sync_next = {step_sync_reg[0], pos_step_in};
    dir_sync_next = {dir_sync_reg[0], pos_dir_in};
    tick_sync_next = {tick_sync_reg[0], tmr_tick_in};
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      step_sync_reg <= 2'h0;
      dir_sync_reg <= 2'h0;
      tick_sync_reg <= 2'h0;
      step_prev_reg <= 1'b0;
      tick_prev_reg <= 1'b0;
    end else begin
      step_sync_reg <= step_sync_next;
      dir_sync_reg <= dir_sync_next;
      tick_sync_reg <= tick_sync_next;
      step_prev_reg <= step_sync_reg[1];
      tick_prev_reg <= tick_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  encoder_word_pkg::bus_phase_t phase_reg;
  encoder_word_pkg::bus_phase_t phase_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;

  always_comb begin
    phase_next = encoder_word_pkg::PH_IDLE;
    addr_next = addr_reg;
    if (hsel_in && hready_in && htrans_in[1]) begin
      phase_next = hwrite_in ? encoder_word_pkg::PH_WRITE : encoder_word_pkg::PH_READ;
      addr_next = haddr_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= encoder_word_pkg::PH_IDLE;
      addr_reg <= 8'h00;
    end else begin
      phase_reg <= phase_next;
      addr_reg <= addr_next;
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  logic wr_act;
  logic rd_act;
  assign wr_act = (phase_reg == encoder_word_pkg::PH_WRITE);
  assign rd_act = (phase_next == encoder_word_pkg::PH_READ);

  ////////////////////////////////////////////////////////////////////////////
  // control and hold registers
  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  encoder_word_pkg::half_word_t hold_reg;
  encoder_word_pkg::half_word_t hold_next;
  logic [31:0] pos_value;
  logic [31:0] tmr_value;
  logic pos_load_high;
  logic pos_load_low;
  logic tmr_load_high;
  logic tmr_load_low;
  logic [15:0] wdata_low;

  assign wdata_low = hwdata_in[15:0];

  always_comb begin
    ctrl_next = ctrl_reg;
    hold_next = hold_reg;
    pos_load_high = 1'b0;
    pos_load_low = 1'b0;
    tmr_load_high = 1'b0;
    tmr_load_low = 1'b0;
    if (wr_act) begin
      case (addr_reg)
        `POS_HIGH_OFS: pos_load_high = 1'b1;
        `POS_LOW_OFS: begin
          pos_load_low = 1'b1;
          pos_load_high = 1'b1;
        end
        `POS_HOLD_OFS: hold_next = wdata_low;
        `TMR_HIGH_OFS: tmr_load_high = 1'b1;
        `TMR_LOW_OFS: tmr_load_low = 1'b1;
        `CTRL_OFS: ctrl_next = hwdata_in[2:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (rd_act && (haddr_in == `POS_LOW_OFS)) begin
      hold_next = pos_value[31:`HALF_SHIFT];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= `CTRL_RESET;
      hold_reg <= `WORD16_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      hold_reg <= hold_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 32-bit values
  logic [15:0] pos_high_src;
  // a low write takes the high half from hold so both halves land together
  assign pos_high_src = (addr_reg == `POS_LOW_OFS) ? hold_reg : wdata_low;

  word_counter32 u_position (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .count_en_in(ctrl_reg[`CTRL_POS_EN_BIT] && step_sync_reg[1] && !step_prev_reg),
    .count_down_in(dir_sync_reg[1] ^ ctrl_reg[`CTRL_DIR_BIT]),
    .load_high_in(pos_load_high),
    .load_low_in(pos_load_low),
    .high_data_in(pos_high_src),
    .low_data_in(wdata_low),
    .value_out(pos_value)
  );

  word_counter32 u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .count_en_in(ctrl_reg[`CTRL_TMR_EN_BIT] && tick_sync_reg[1] && !tick_prev_reg),
    .count_down_in(1'b0),
    .load_high_in(tmr_load_high),
    .load_low_in(tmr_load_low),
    .high_data_in(wdata_low),
    .low_data_in(wdata_low),
    .value_out(tmr_value)
  );

  assign position_count_32_out = pos_value;
  assign interval_timer_32_out = tmr_value;

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered at the address phase
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (rd_act) begin
      case (haddr_in)
        `POS_HIGH_OFS: rdata_next = {16'h0000, pos_value[31:`HALF_SHIFT]};
        `POS_LOW_OFS: rdata_next = {16'h0000, pos_value[15:0]};
        `POS_HOLD_OFS: rdata_next = {16'h0000, hold_reg};
        `TMR_HIGH_OFS: rdata_next = {16'h0000, tmr_value[31:`HALF_SHIFT]};
        `TMR_LOW_OFS: rdata_next = {16'h0000, tmr_value[15:0]};
        `CTRL_OFS: rdata_next = {29'h0000_0000, ctrl_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata_out = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_low_read_latch: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_act && haddr_in == `POS_LOW_OFS) |=> (hold_reg == $past(pos_value[31:16])))
    else $error("hold not latched on low read");
  a_low_write_load: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_act && addr_reg == `POS_LOW_OFS) |=>
      (pos_value == {$past(hold_reg), $past(hwdata_in[15:0])}))
    else $error("low write did not load both halves");
  a_pos_high_read: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_act && haddr_in == `POS_HIGH_OFS) |=> (hrdata_out == {16'h0000, $past(pos_value[31:16])}))
    else $error("position high read wrong");
  a_pos_low_read: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_act && haddr_in == `POS_LOW_OFS) |=> (hrdata_out == {16'h0000, $past(pos_value[15:0])}))
    else $error("position low read wrong");
  a_hold_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_act && addr_reg == `POS_HOLD_OFS && !(rd_act && haddr_in == `POS_LOW_OFS))
      |=> (hold_reg == $past(hwdata_in[15:0])))
    else $error("hold write lost");
  a_tmr_high_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_act && addr_reg == `TMR_HIGH_OFS) |=> (tmr_value[31:16] == $past(hwdata_in[15:0])))
    else $error("timer high write lost");
  a_tmr_low_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_act && addr_reg == `TMR_LOW_OFS) |=> (tmr_value[15:0] == $past(hwdata_in[15:0])))
    else $error("timer low write lost");
  a_tmr_high_read: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_act && haddr_in == `TMR_HIGH_OFS) |=>
      (hrdata_out == {16'h0000, $past(tmr_value[31:16])}))
    else $error("timer high read wrong");
endmodule : encoder_counter_word_access

// ---- verification/encoder_pins_model.sv ----
`timescale 1ns/1ps
// step/direction and tick pins as the far side drives them: direction settles before each step edge
module encoder_pins_model (
  input wire logic clock_in,
  output logic pos_step_out,
  output logic pos_dir_out,
  output logic tmr_tick_out
);
  initial begin
    pos_step_out = 1'b0;
    pos_dir_out = 1'b0;
    tmr_tick_out = 1'b0;
  end
  // one clean edge on the step or tick pin, held long enough for the 2-ff sync
  task automatic pulse(input logic tick, input logic dir);
    pos_dir_out <= dir;
    repeat (2) @(posedge clock_in);
    if (tick) tmr_tick_out <= 1'b1;
    else pos_step_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    tmr_tick_out <= 1'b0;
    pos_step_out <= 1'b0;
    repeat (6) @(posedge clock_in);
  endtask : pulse
endmodule : encoder_pins_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clock_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd, pos, tmr;
  logic hresp, step, dir, tick;
  int n_errors = 0, checks = 0, cyc = 0;
  row_t rows[5] = '{'{8'h0c, 32'hffff1234, 32'h1234}, '{8'h10, 32'h00005678, 32'h5678},
    '{8'h00, 32'h0000beef, 32'hbeef}, '{8'h08, 32'h000000c3, 32'hc3},
    '{8'h18, 32'h0000ffff, 32'h0}};
  encoder_counter_word_access encoder_counter_word_access_i (.clock_in(clock_in),
    .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .pos_step_in(step), .pos_dir_in(dir), .tmr_tick_in(tick), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .position_count_32_out(pos),
    .interval_timer_32_out(tmr));
  encoder_pins_model encoder_pins_model_i (.clock_in(clock_in), .pos_step_out(step),
    .pos_dir_out(dir), .tmr_tick_out(tick));
  always #12.5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // single word transfer: address phase, then data phase, each until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_in); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    hsel <= 1'b0;
  endtask : bus
  task automatic settle();
    repeat (2) @(posedge clock_in);
    #1;
  endtask : settle
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk("readback", rd, rows[i].e);
    end
    settle();
    chk("timer out", tmr, 32'h12345678);
    chk("position out", pos, 32'hbeef0000);
    // coherent 32-bit write through the hold register, then coherent read
    bus(1'b1, 8'h08, 32'habcd);
    bus(1'b1, 8'h04, 32'h5678);
    settle();
    chk("position load", pos, 32'habcd5678);
    bus(1'b1, 8'h08, 32'h1111);
    bus(1'b0, 8'h04, 32'h0);
    chk("low read", rd, 32'h5678);
    bus(1'b0, 8'h08, 32'h0);
    chk("hold latched", rd, 32'habcd);
    // carry and borrow across the two halves while counting
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h04, 32'hffff);
    bus(1'b1, 8'h14, 32'h1);
    encoder_pins_model_i.pulse(1'b0, 1'b0);
    bus(1'b0, 8'h04, 32'h0);
    chk("low after carry", rd, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk("hold after carry", rd, 32'h1);
    encoder_pins_model_i.pulse(1'b0, 1'b1);
    settle();
    chk("borrow", pos, 32'hffff);
    bus(1'b1, 8'h14, 32'h2);
    encoder_pins_model_i.pulse(1'b0, 1'b0);
    encoder_pins_model_i.pulse(1'b1, 1'b0);
    settle();
    chk("position disabled", pos, 32'hffff);
    chk("timer tick", tmr, 32'h1234567a - 32'h1);
    bus(1'b0, 8'h0c, 32'h0);
    chk("timer high read", rd, 32'h1234);
    // direction invert: a low dir pin now counts down
    bus(1'b1, 8'h14, 32'h5);
    bus(1'b0, 8'h14, 32'h0);
    chk("control readback", rd, 32'h5);
    encoder_pins_model_i.pulse(1'b0, 1'b0);
    settle();
    chk("inverted step", pos, 32'hfffe);
    // reset in mid-run clears everything
    rst_in <= 1'b1;
    settle();
    chk("reset position", pos, 32'h0);
    chk("reset timer", tmr, 32'h0);
    chk("reset rdata", hrdata, 32'h0);
    @(posedge clock_in);
    rst_in <= 1'b0;
    bus(1'b0, 8'h08, 32'h0);
    chk("reset hold", rd, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk("reset control", rd, 32'h0);
    conclude();
  end
endmodule : testbench
